// file: acr_router.sv
// Audio channel router: input settings, output scaling, PDM and analog bit outputs
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module acr_router
  import acr_pkg::*;
#(
  parameter int W = SMP_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Converter samples in, gained samples out
  input wire logic signed [W-1:0] adc_sample0,
  input wire logic signed [W-1:0] adc_sample1,
  input wire logic adc_valid,
  output logic adc_rate_strobe,
  output logic signed [W-1:0] gained_sample0,
  output logic signed [W-1:0] gained_sample1,
  output logic gained_valid,
  // Processor results
  input wire logic signed [W-1:0] proc_sample,
  input wire logic signed [W-1:0] raw_sample,
  input wire logic out_valid,
  // Analog front-end settings
  output logic [7:0] in_cfg0,
  output logic [7:0] in_cfg1,
  output logic mic_bias_setting,
  // Pins
  input wire logic external_clock_in,
  input wire logic algorithm_select_pin,
  output logic pdm_data_out,
  output logic pdm_data_oe,
  output logic analog_out_zero,
  output logic analog_out_one
);
  // Register map, one 32-bit word per byte offset, word aligned:
  //   CTRL     algorithm enable, mono, right and left channel select,
  //            right and left mute, analog path, mic bias
  //   IN_CFG   front-end settings, channel 0 in the low byte, channel 1 above
  //            [1:0] input select, [4:2] preamp, [6:5] high-pass, [7] low-pass
  //   DGAIN    input digital gain, Q1.15, channel 0 in the low half
  //   RATE     converter sample-rate divider, in system clocks
  //   OGAIN0/1 output gain, Q1.15 fraction plus a signed 4-bit shift
  //   STATUS   read-only: effective algorithm state and synchronised pins
  // Unmapped offsets read zero and ignore writes; writes to STATUS are dropped.
  // Software may change any field at any time; the converter rate should only
  // be changed with the algorithm off, since the processor relies on it.

  // All module state in one record; the next-state logic edits a copy of it
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] in_cfg;
    logic [31:0] dgain;
    logic [15:0] rate;
    logic [19:0] og0;
    logic [19:0] og1;
    logic ack;
    logic [31:0] rdata;
    logic [2:0] ck_sync;
    logic [1:0] al_sync;
    logic [15:0] rate_cnt;
    logic rate_stb;
    logic [7:0] div_cnt;
    logic signed [W-1:0] ch0;
    logic signed [W-1:0] ch1;
    logic signed [W-1:0] g0;
    logic signed [W-1:0] g1;
    logic gvalid;
    logic pdm;
    logic a0;
    logic a1;
  } acr_st_type;

  acr_st_type st_q, st_d;

  initial begin
    if (W != SMP_W) $error("acr_router: W must equal the converter width");
    if (MOD_DIV < 2 || MOD_DIV > 256) $error("acr_router: modulator divider out of range");
    if (RATE_DIV < 1 || RATE_DIV > 65535) $error("acr_router: sample-rate divider out of range");
  end

  // Multiply by Q1.15 fraction, then signed shift, then saturate.
  // Saturation follows the shift, so a large positive shift clips at full
  // scale instead of wrapping into the opposite sign.
  function automatic logic signed [W-1:0] scale(input logic signed [W-1:0] x,
                                                 input logic [19:0] g);
    logic signed [31:0] v;
    logic signed [3:0] sh;
    v = 32'(x) * 32'(signed'(g[15:0]));
    v = v >>> FRAC_BITS;
    sh = signed'(g[OG_SHIFT+3:OG_SHIFT]);
    if (sh >= 0) v = v <<< sh;
    else v = v >>> (-sh);
    if (v > SAT_MAX) v = SAT_MAX;
    if (v < SAT_MIN) v = SAT_MIN;
    scale = v[W-1:0];
  endfunction : scale

  // Decoded control, pin edges and modulator links
  logic algo_eff;
  logic ck_rise;
  logic ck_fall;
  logic step;
  logic req;
  logic [31:0] rd_mux;
  logic [1:0] mod_bit;
  logic signed [W-1:0] mod_level [2];

  // Pin overrides: a high algorithm pin inverts the software bit.
  // Only the synchronised level is used, so both channels always see the
  // same algorithm state within one cycle.
  assign algo_eff = st_q.ctrl[CB_ALGO] ^ st_q.al_sync[1];
  assign ck_rise = st_q.ck_sync[1] & ~st_q.ck_sync[2];
  assign ck_fall = ~st_q.ck_sync[1] & st_q.ck_sync[2];
  // Modulators step on host clock rise, or on the internal divider for analog.
  // On the analog path the host clock may be absent altogether, so the
  // divider keeps the modulators running on their own.
  assign step = st_q.ctrl[CB_ANALOG] ? (st_q.div_cnt == 8'(MOD_DIV - 1)) : ck_rise;
  assign req = avs_read | avs_write;

  // Read multiplexer; unmapped addresses read zero.
  // Status bits are live synchronised levels, handy to see the host clock toggle.
  always_comb begin
    case (avs_address)
      OFF_CTRL: rd_mux = 32'(st_q.ctrl);
      OFF_IN_CFG: rd_mux = 32'(st_q.in_cfg);
      OFF_DGAIN: rd_mux = st_q.dgain;
      OFF_RATE: rd_mux = 32'(st_q.rate);
      OFF_OGAIN0: rd_mux = 32'(st_q.og0);
      OFF_OGAIN1: rd_mux = 32'(st_q.og1);
      OFF_STATUS: rd_mux = {29'h0, st_q.ck_sync[1], st_q.al_sync[1], algo_eff};
      default: rd_mux = 32'h0;
    endcase
  end

  // Next-state logic
  always_comb begin
    logic signed [31:0] p0;
    logic signed [31:0] p1;
    p0 = '0;
    p1 = '0;
    st_d = st_q;
    // Two-stage synchronisers, third stage only for edge finding.
    // The host bit clock is unrelated to clk, so only stage two reads stage
    // one; stage three merely remembers the previous settled level.
    st_d.ck_sync = {st_q.ck_sync[1:0], external_clock_in};
    st_d.al_sync = {st_q.al_sync[0], algorithm_select_pin};
    // Bus: every request waits exactly one cycle. Read data are captured in
    // the wait cycle, so they stand still at the edge where the master sees
    // waitrequest low; a write lands at that same edge. A request held past
    // that edge simply starts a fresh two-cycle access.
    st_d.ack = req & ~st_q.ack;
    if (req && !st_q.ack) begin
      st_d.rdata = rd_mux;
    end
    if (avs_write && st_q.ack) begin
      case (avs_address)
        OFF_CTRL: st_d.ctrl = avs_writedata[CTRL_W-1:0];
        OFF_IN_CFG: st_d.in_cfg = avs_writedata[15:0];
        OFF_DGAIN: st_d.dgain = avs_writedata;
        OFF_RATE: st_d.rate = avs_writedata[15:0];
        OFF_OGAIN0: st_d.og0 = avs_writedata[19:0];
        OFF_OGAIN1: st_d.og1 = avs_writedata[19:0];
        default: st_d.rate = st_q.rate;
      endcase
    end
    // Sample-rate strobe; a zero or one divider still strobes every cycle.
    // Rewriting the divider below the running count gives one early strobe,
    // traded for not having to clear the counter on every write.
    st_d.rate_stb = 1'b0;
    if (st_q.rate_cnt + 16'h1 >= st_q.rate) begin
      st_d.rate_cnt = 16'h0;
      st_d.rate_stb = 1'b1;
    end else begin
      st_d.rate_cnt = st_q.rate_cnt + 16'h1;
    end
    // Input digital gain, Q1.15 per converter channel.
    // Products are truncated, not saturated: a positive Q1.15 gain is below
    // one, so a full-scale sample cannot overflow.
    st_d.gvalid = adc_valid;
    if (adc_valid) begin
      p0 = (32'(adc_sample0) * 32'(signed'(st_q.dgain[15:0]))) >>> FRAC_BITS;
      p1 = (32'(adc_sample1) * 32'(signed'(st_q.dgain[31:16]))) >>> FRAC_BITS;
      st_d.g0 = p0[W-1:0];
      st_d.g1 = p1[W-1:0];
    end
    // Channel routing follows the live algorithm state, so a toggle swaps them.
    // The swap takes effect at the next processor result; the modulators are
    // not drained, so a few bits of the old content may still follow.
    if (out_valid) begin
      st_d.ch0 = scale(algo_eff ? proc_sample : raw_sample, st_q.og0);
      st_d.ch1 = scale(algo_eff ? raw_sample : proc_sample, st_q.og1);
    end
    // Internal modulator clock divider for the analog path
    // It free-runs in every mode; only the analog path listens to it.
    st_d.div_cnt = (st_q.div_cnt == 8'(MOD_DIV - 1)) ? 8'h0 : st_q.div_cnt + 8'h1;
    // Digital mic: right side on rising edge, left side on falling edge.
    // The output flop changes about three system clocks after the pin edge,
    // well inside half of the fastest host period, so each side is settled
    // when the host samples it on the opposite edge. A muted side drives zero
    // rather than releasing the pin, so the host never reads a floating line.
    if (ck_rise) begin
      st_d.pdm = st_q.ctrl[CB_RMUTE] ? 1'b0 :
                 (st_q.ctrl[CB_RSEL] ? mod_bit[1] : mod_bit[0]);
    end else if (ck_fall) begin
      st_d.pdm = st_q.ctrl[CB_LMUTE] ? 1'b0 :
                 (st_q.ctrl[CB_LSEL] ? mod_bit[1] : mod_bit[0]);
    end
    // Analog bit streams: stereo carries both, mono inverts channel 0.
    // Both pins update on the same step, so the pair never skews by a bit.
    if (step) begin
      st_d.a0 = mod_bit[0];
      st_d.a1 = st_q.ctrl[CB_MONO] ? ~mod_bit[0] : mod_bit[1];
    end
  end

  // Modulator levels come straight from the channel registers
  assign mod_level[0] = st_q.ch0;
  assign mod_level[1] = st_q.ch1;

  // One modulator per output channel; both share one step, taken at the host clock rise on the digital mic path, so the right
  // side of a host period carries the bit from before that step and the left side the bit from after it
  for (genvar i = 0; i < 2; i++) begin : g_mod
    acr_sdm_if link ();
    assign link.step = step;
    assign link.level = mod_level[i];
    assign mod_bit[i] = link.bit_out;
    acr_sdm #(.W(W)) u_sdm (
      .clk(clk),
      .rst_n(rst_n),
      .sdm(link.mdl)
    );
  end

  // State register; programmable registers take their preset values.
  // Everything else restarts from zero, so the modulators begin from an
  // empty integrator and the pdm and analog data pins start low.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.ctrl <= CTRL_RST;
      st_q.in_cfg <= IN_CFG_RST;
      st_q.dgain <= DGAIN_RST;
      st_q.rate <= RATE_RST;
      st_q.og0 <= OGAIN_RST;
      st_q.og1 <= OGAIN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs
  // Waitrequest is combinational so the wait cycle costs no extra latency
  assign avs_waitrequest = req & ~st_q.ack;
  assign avs_readdata = st_q.rdata;
  assign adc_rate_strobe = st_q.rate_stb;
  assign gained_sample0 = st_q.g0;
  assign gained_sample1 = st_q.g1;
  assign gained_valid = st_q.gvalid;
  assign in_cfg0 = st_q.in_cfg[7:0];
  assign in_cfg1 = st_q.in_cfg[15:8];
  assign mic_bias_setting = st_q.ctrl[CB_BIAS];
  assign pdm_data_out = st_q.pdm;
  assign pdm_data_oe = ~st_q.ctrl[CB_ANALOG]; // Drives only on the digital mic path
  assign analog_out_zero = st_q.a0;
  assign analog_out_one = st_q.a1;
endmodule : acr_router
`default_nettype wire

// file: acr_pkg.sv
// Constants and register map for the audio channel router
package acr_pkg;
  // System clock and derived rates
  localparam int CLK_HZ = 50000000;
  localparam int FS_HZ = 16000;
  localparam int RATE_DIV = CLK_HZ / FS_HZ;
  localparam int MOD_HZ = 3125000;
  localparam int MOD_DIV = CLK_HZ / MOD_HZ;
  // Sample width of the converters
  localparam int SMP_W = 16;
  // Register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_IN_CFG = 5'h04;
  localparam logic [4:0] OFF_DGAIN = 5'h08;
  localparam logic [4:0] OFF_RATE = 5'h0c;
  localparam logic [4:0] OFF_OGAIN0 = 5'h10;
  localparam logic [4:0] OFF_OGAIN1 = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;
  // Control register bit positions
  localparam int CB_ALGO = 0;
  localparam int CB_MONO = 1;
  localparam int CB_RSEL = 2;
  localparam int CB_LSEL = 3;
  localparam int CB_RMUTE = 4;
  localparam int CB_LMUTE = 5;
  localparam int CB_ANALOG = 6;
  localparam int CB_BIAS = 7;
  localparam int CTRL_W = 8;
  // Control reset: algorithm on, stereo, right=ch0, left=ch1, digital mic path
  localparam logic [7:0] CTRL_RST = 8'h09;
  // Input config per channel: [1:0] select, [4:2] preamp, [6:5] high-pass, [7] low-pass
  localparam logic [15:0] IN_CFG_RST = 16'he1e0;
  localparam logic [31:0] DGAIN_RST = 32'h7fff7fff;
  localparam logic [15:0] RATE_RST = 16'(RATE_DIV);
  // Output gain: [15:0] fractional Q1.15, [19:16] signed shift count
  localparam logic [19:0] OGAIN_RST = 20'h07fff;
  localparam int OG_SHIFT = 16;
  localparam int FRAC_BITS = 15;
  localparam logic signed [31:0] SAT_MAX = 32'sh00007fff;
  localparam logic signed [31:0] SAT_MIN = -32'sh00008000;
endpackage : acr_pkg

// file: acr_sdm_if.sv
// Link between the router and one sigma-delta modulator
`timescale 1ns/1ps
`default_nettype none
interface acr_sdm_if;
  logic step;
  logic signed [15:0] level;
  logic bit_out;
  modport host (output step, output level, input bit_out);
  modport mdl (input step, input level, output bit_out);
endinterface : acr_sdm_if
`default_nettype wire

// file: acr_sdm.sv
// First-order sigma-delta modulator producing a pulse-density bit
`timescale 1ns/1ps
`default_nettype none
module acr_sdm
  import acr_pkg::*;
#(
  parameter int W = SMP_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Modulator link
  acr_sdm_if.mdl sdm
);
  typedef struct packed {
    logic signed [W+1:0] acc;
    logic bit_q;
  } acr_sdm_st_type;

  acr_sdm_st_type st_q, st_d;

  initial begin
    if (W < 4 || W > 16) $error("acr_sdm: W out of range");
  end

  // Integrate error against full-scale feedback once per step
  always_comb begin
    logic signed [W+1:0] fb;
    fb = st_q.bit_q ? (W+2)'(1 <<< (W-1)) : -(W+2)'(1 <<< (W-1));
    st_d = st_q;
    if (sdm.step) begin
      st_d.acc = st_q.acc + (W+2)'(sdm.level) - fb;
      st_d.bit_q = ~st_d.acc[W+1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sdm.bit_out = st_q.bit_q;
endmodule : acr_sdm
`default_nettype wire

// file: acr_router_asserts.sv
// Port checks for the audio channel router
`timescale 1ns/1ps
`default_nettype none
module acr_router_chk
  import acr_pkg::*;
(
  // Clock and bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Samples and pins
  input wire logic adc_valid,
  input wire logic gained_valid,
  input wire logic adc_rate_strobe,
  input wire logic [7:0] in_cfg0,
  input wire logic pdm_data_oe,
  input wire logic external_clock_in,
  input wire logic pdm_data_out
);
  logic wr_ok;
  // A write lands only at the edge that ends the wait state
  assign wr_ok = avs_write && !avs_waitrequest;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wait_one_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 5'h18 |-> !avs_readdata)
    else $error("unmapped read");
  gain_valid_a: assert property (adc_valid |=> gained_valid)
    else $error("gain late");
  gain_cause_a: assert property (gained_valid |-> $past(adc_valid))
    else $error("gain uncaused");
  strobe_gap_a: assert property (adc_rate_strobe |=> !adc_rate_strobe [*8])
    else $error("rate strobe");
  cfg_write_a: assert property ($changed(in_cfg0) |-> $past(wr_ok && avs_address == OFF_IN_CFG))
    else $error("front-end change");
  oe_write_a: assert property ($changed(pdm_data_oe) |-> $past(wr_ok && avs_address == OFF_CTRL))
    else $error("mode change");
  pdm_edge_a: assert property ($changed(pdm_data_out) |-> $past(external_clock_in) != $past(external_clock_in, 6))
    else $error("pdm bit off edge");
endmodule : acr_router_chk
bind acr_router acr_router_chk u_chk (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .adc_valid, .gained_valid, .adc_rate_strobe, .in_cfg0, .pdm_data_oe, .external_clock_in,
  .pdm_data_out);
`default_nettype wire

// file: acr_host.sv
// Digital microphone host: bit clock and per-side ones count
`timescale 1ns/1ps
`default_nettype none
module acr_host (
  // Frame control
  input wire logic run,
  // Link
  output logic pdm_clk,
  input wire logic pdm_data
);
  int ones_r;
  int ones_l;
  // 160 ns period; finishes a high phase, then stands still low between frames
  initial begin
    pdm_clk = 1'b0;
    #7;
    forever begin
      #80;
      if (run || pdm_clk) pdm_clk = ~pdm_clk;
    end
  end
  // Right taken at the fall, left at the rise
  always @(negedge pdm_clk) ones_r += pdm_data;
  always @(posedge pdm_clk) ones_l += pdm_data;
endmodule : acr_host
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the audio channel router
`timescale 1ns/1ps
`default_nettype none
module testbench
  import acr_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic signed [15:0] adc_sample0 = 16'sh1000;
  logic signed [15:0] adc_sample1 = 16'sh1000;
  logic signed [15:0] proc_sample = 16'sh6000;
  logic signed [15:0] raw_sample = -16'sh6000;
  logic adc_valid = 1'b0;
  logic out_valid = 1'b0;
  logic algorithm_select_pin = 1'b0;
  logic run = 1'b0;
  logic [31:0] avs_readdata;
  logic signed [15:0] gained_sample0, gained_sample1;
  logic [7:0] in_cfg0, in_cfg1;
  logic avs_waitrequest, adc_rate_strobe, gained_valid, mic_bias_setting, external_clock_in;
  logic pdm_data_out, pdm_data_oe, analog_out_zero, analog_out_one;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  acr_router dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .adc_sample0, .adc_sample1, .adc_valid, .adc_rate_strobe, .gained_sample0, .gained_sample1,
    .gained_valid, .proc_sample, .raw_sample, .out_valid, .in_cfg0, .in_cfg1, .mic_bias_setting,
    .external_clock_in, .algorithm_select_pin, .pdm_data_out, .pdm_data_oe, .analog_out_zero, .analog_out_one);
  acr_host host (.run, .pdm_clk(external_clock_in), .pdm_data(pdm_data_out));
  // Clock, processor results every other cycle, hang limit
  always #10 clk = ~clk;
  always @(posedge clk) out_valid <= ~out_valid;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Bus cycle held until waitrequest is low; a read compares with d
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    if (!w) chk(avs_readdata, d);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  // Density class of 64 bits: none, low, middle, high, or 4 for a count between classes
  function automatic logic [31:0] cls(input int n);
    if (n == 0) return 32'h0;
    if (n <= 16) return 32'h1;
    if (n >= 24 && n <= 44) return 32'h2;
    return n >= 50 ? 32'h3 : 32'h4;
  endfunction : cls
  // One frame of 64 host periods after a short settle
  task automatic sides(input logic [31:0] er, input logic [31:0] el);
    run <= 1'b1;
    repeat (64) @(posedge clk);
    host.ones_r = 0;
    host.ones_l = 0;
    repeat (512) @(posedge clk);
    run <= 1'b0;
    chk(cls(host.ones_r), er);
    chk(cls(host.ones_l), el);
  endtask : sides
  // Analog bit streams over 64 modulator steps after a short settle
  task automatic analog(input logic [31:0] e0, input logic [31:0] e1);
    int n0 = 0;
    int n1 = 0;
    repeat (64) @(posedge clk);
    repeat (64 * MOD_DIV) begin
      @(posedge clk);
      n0 += analog_out_zero;
      n1 += analog_out_one;
    end
    chk(cls(n0 / MOD_DIV), e0);
    chk(cls(n1 / MOD_DIV), e1);
  endtask : analog
  task automatic t_reset;
    bus(1'b0, OFF_CTRL, 32'h09);
    bus(1'b0, OFF_IN_CFG, 32'he1e0);
    bus(1'b0, 5'h1c, 32'h0);
    bus(1'b0, OFF_STATUS, 32'h1);
    chk(pdm_data_oe, 32'h1);
    chk(mic_bias_setting, 32'h0);
  endtask : t_reset
  task automatic t_front;
    bus(1'b1, OFF_IN_CFG, 32'h9c47);
    chk({in_cfg1, in_cfg0}, 32'h9c47);
    bus(1'b1, OFF_DGAIN, 32'h20004000);
    adc_valid <= 1'b1;
    @(posedge clk);
    adc_valid <= 1'b0;
    @(posedge clk);
    chk({gained_sample1, gained_sample0}, 32'h04000800);
  endtask : t_front
  task automatic t_route;
    sides(32'h3, 32'h1);
    bus(1'b1, OFF_CTRL, 32'h08);
    sides(32'h1, 32'h3);
    algorithm_select_pin <= 1'b1;
    sides(32'h3, 32'h1);
    algorithm_select_pin <= 1'b0;
    bus(1'b1, OFF_CTRL, 32'h01);
    sides(32'h3, 32'h3);
    bus(1'b1, OFF_CTRL, 32'h19);
    sides(32'h0, 32'h1);
    bus(1'b1, OFF_CTRL, 32'h29);
    sides(32'h3, 32'h0);
  endtask : t_route
  task automatic t_scale;
    bus(1'b1, OFF_CTRL, 32'h09);
    bus(1'b1, OFF_OGAIN0, 32'h22000);
    sides(32'h3, 32'h1);
    bus(1'b1, OFF_OGAIN0, 32'h02000);
    sides(32'h2, 32'h1);
    bus(1'b1, OFF_OGAIN0, 32'he7fff);
    sides(32'h2, 32'h1);
  endtask : t_scale
  task automatic t_rate;
    int n = 0;
    bus(1'b1, OFF_CTRL, 32'h88);
    chk(mic_bias_setting, 32'h1);
    bus(1'b1, OFF_RATE, 32'h20);
    bus(1'b0, OFF_RATE, 32'h20);
    do begin
      @(posedge clk);
    end while (adc_rate_strobe !== 1'b1);
    do begin
      @(posedge clk);
      n++;
    end while (adc_rate_strobe !== 1'b1);
    chk(n, 32'h20);
    bus(1'b1, OFF_RATE, 32'(RATE_RST));
  endtask : t_rate
  task automatic t_mono;
    bus(1'b1, OFF_OGAIN0, 32'h07fff);
    bus(1'b1, OFF_OGAIN1, 32'h07fff);
    bus(1'b0, OFF_OGAIN1, 32'h07fff);
    bus(1'b1, OFF_CTRL, 32'h41);
    analog(32'h3, 32'h1);
    bus(1'b1, OFF_CTRL, 32'h40);
    analog(32'h1, 32'h3);
    bus(1'b1, OFF_CTRL, 32'h4b);
    chk(pdm_data_oe, 32'h0);
    repeat (40) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      chk(analog_out_one ^ analog_out_zero, 32'h1);
    end
  endtask : t_mono
  task automatic end_of_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Reset for 16 cycles, then the scenarios
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_front();
    t_route();
    t_scale();
    t_rate();
    t_mono();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
